// ===== core/fcl_pkg.sv
// constants shared by the configuration loader
package fcl_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int WAKE_TIME_NS = 30000;
    localparam int WAKE_CYC = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_DIV = 4;
    localparam int DUMMY_CLKS = 8;
    // ----------------------------------------------------------------
    // serial flash instructions
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_WAKE = 8'hab;
    localparam logic [7:0] CMD_READ_X1 = 8'h0b;
    localparam logic [7:0] CMD_READ_X2 = 8'h3b;
    localparam logic [7:0] CMD_READ_X4 = 8'h6b;
    localparam logic [23:0] READ_ADDR = 24'h000000;
    localparam int CMD_BITS = 32;
    localparam int WAKE_BITS = 8;
    // ----------------------------------------------------------------
    // mode and width straps
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_ACTIVE = 2'h0;
    localparam logic [1:0] MODE_PASSIVE = 2'h1;
    localparam logic [1:0] MODE_JTAG = 2'h2;
    localparam logic [2:0] WID_X1 = 3'h0;
    localparam logic [2:0] WID_X4 = 3'h2;
    localparam logic [2:0] WID_X32 = 3'h5;
    localparam int BIT_WORDS = 64;
    typedef enum {ST_IDLE, ST_WAKE, ST_GAP, ST_CMD, ST_DUMMY, ST_DATA, ST_STREAM, ST_DRAIN, ST_USER, ST_ERR} fcl_state_e;
endpackage

// ===== core/fcl_loader.sv
// configuration loader: flash master, passive slave, jtag path, fifo
// Overview of operation
// RULE1: logic held off until memory fully loaded
// RULE2: modes active x1-x4, passive x1-x32, jtag x1
// RULE3: outside party holds reset low before release
// RULE4: active load starts on reset rising edge
// RULE5: active mode clocks flash from internal divider
// RULE6: first flash instruction is wake-up
// RULE7: wait 30 us, then fast read address zero
// RULE8: flash sends data only when read
// RULE9: passive mode: outside master drives clock, data
// RULE10: jtag mode loads bitstream through test port
// RULE11: one continuous read until bitstream complete
`timescale 1ns/100ps

// ----------------------------------------------------------------
// word fifo
// ----------------------------------------------------------------
module fcl_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clock, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // space available
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // read accept
    output logic [WIDTH-1:0] out_data // read word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ff;
    logic [AW:0] rd_ff;
    wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    wire empty = (wr_ff == rd_ff);
    wire do_wr = in_valid && !full;
    wire do_rd = out_valid && out_ready;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ff[AW-1:0]];
    // storage
    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end
    // pointers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            if (do_wr) wr_ff <= wr_ff + 1'b1;
            if (do_rd) rd_ff <= rd_ff + 1'b1;
        end
    end
endmodule

// ----------------------------------------------------------------
// loader top
// ----------------------------------------------------------------
module fcl_loader #(
    parameter int WORDS = fcl_pkg::BIT_WORDS,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clock, // 50 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic config_reset_low, // configuration reset pin
    input wire logic [1:0] mode_sel, // mode strap pins
    input wire logic [2:0] width_sel, // width strap pins
    output logic spi_sck, // flash clock
    output logic spi_cs_n, // flash select, active low
    output logic [3:0] spi_io_out, // flash data lanes out
    output logic [3:0] spi_io_oe, // flash lane drive enables
    input wire logic [3:0] spi_io_in, // flash data lanes in
    input wire logic pas_clk, // passive clock from master
    input wire logic pas_cs_n, // passive select, active low
    input wire logic [31:0] pas_data, // passive data bus
    output logic pas_busy, // passive back-pressure
    input wire logic jtag_tck, // test clock
    input wire logic jtag_cfg_en, // test port load enable
    input wire logic jtag_tdi, // test data in
    output logic [31:0] cm_wdata, // configuration_memory word
    output logic cm_wvalid, // configuration_memory write
    input wire logic cm_wready, // configuration_memory accept
    output logic user_mode, // normal operation enabled
    output logic cfg_error // illegal mode or width strap, or overrun
);
    import fcl_pkg::*;

    // beats per 32-bit word for a width code
    function automatic logic [5:0] beats_per_word(input logic [2:0] code);
        beats_per_word = 6'h20 >> code;
    endfunction

    // shift a beat into the assembly word
    function automatic logic [31:0] shift_in(input logic [31:0] acc, input logic [31:0] d, input logic [2:0] code);
        case (code)
            3'h0: shift_in = {acc[30:0], d[0]};
            3'h1: shift_in = {acc[29:0], d[1:0]};
            3'h2: shift_in = {acc[27:0], d[3:0]};
            3'h3: shift_in = {acc[23:0], d[7:0]};
            3'h4: shift_in = {acc[15:0], d[15:0]};
            default: shift_in = d;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [46:0] sync1_ff;
    logic [46:0] sync2_ff;
    logic cr_d_ff;
    logic pclk_d_ff;
    logic tck_d_ff;
    wire [46:0] pins = {config_reset_low, mode_sel, width_sel, spi_io_in, pas_clk, pas_cs_n, pas_data,
                        jtag_tck, jtag_cfg_en, jtag_tdi};
    wire cr_s = sync2_ff[46];
    wire [1:0] mode_s = sync2_ff[45:44];
    wire [2:0] width_s = sync2_ff[43:41];
    wire [3:0] io_s = sync2_ff[40:37];
    wire pclk_s = sync2_ff[36];
    wire pcs_n_s = sync2_ff[35];
    wire [31:0] pdata_s = sync2_ff[34:3];
    wire tck_sy = sync2_ff[2];
    wire ten_sy = sync2_ff[1];
    wire tdi_sy = sync2_ff[0];
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            cr_d_ff <= 1'b0;
            pclk_d_ff <= 1'b0;
            tck_d_ff <= 1'b0;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
            cr_d_ff <= cr_s;
            pclk_d_ff <= pclk_s;
            tck_d_ff <= tck_sy;
        end
    end
    wire cr_rise = cr_s && !cr_d_ff;
    wire pclk_rise = pclk_s && !pclk_d_ff;
    wire tck_rise = tck_sy && !tck_d_ff;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    fcl_state_e state_ff;
    fcl_state_e nxt_state;
    logic [1:0] mode_ff;
    logic [2:0] wcode_ff;
    logic [$clog2(SCK_DIV)-1:0] div_ff;
    logic [15:0] wait_ff;
    logic [5:0] bit_ff;
    logic [5:0] beat_ff;
    logic [31:0] tx_sr_ff;
    logic [31:0] asm_ff;
    logic word_vld_ff;
    logic [15:0] rx_cnt_ff;
    logic [15:0] cm_cnt_ff;
    logic sck_ff;
    logic cs_n_ff;
    logic [3:0] oe_ff;
    logic wvalid_ff;
    logic [31:0] wdata_ff;
    logic user_ff;
    logic err_ff;
    logic busy_ff;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;

    // strap decode and legal widths
    wire width_ok = (mode_s == MODE_ACTIVE) ? (width_s <= WID_X4) :
                    (mode_s == MODE_PASSIVE) ? (width_s <= WID_X32) :
                    (mode_s == MODE_JTAG) ? (width_s == WID_X1) : 1'b0; // RULE2
    wire [7:0] read_cmd = (wcode_ff == 3'h0) ? CMD_READ_X1 : (wcode_ff == 3'h1) ? CMD_READ_X2 : CMD_READ_X4;
    wire sck_state = (state_ff == ST_WAKE) || (state_ff == ST_CMD) || (state_ff == ST_DUMMY) ||
                     (state_ff == ST_DATA);
    wire stall = word_vld_ff && !fifo_in_ready;
    wire tick = sck_state && !stall && (div_ff == ($clog2(SCK_DIV))'(SCK_DIV - 1)); // RULE5
    wire fall_tick = tick && sck_ff;
    wire phase_end_wake = fall_tick && (bit_ff == 6'(WAKE_BITS - 1));
    wire phase_end_cmd = fall_tick && (bit_ff == 6'(CMD_BITS - 1));
    wire phase_end_dummy = fall_tick && (bit_ff == 6'(DUMMY_CLKS - 1));
    wire [31:0] act_lanes = (wcode_ff == 3'h0) ? {31'h0, io_s[1]} : {28'h0, io_s};
    wire act_beat = (state_ff == ST_DATA) && fall_tick; // RULE8
    wire pas_beat = (state_ff == ST_STREAM) && (mode_ff == MODE_PASSIVE) && pclk_rise && !pcs_n_s; // RULE9
    wire jtg_beat = (state_ff == ST_STREAM) && (mode_ff == MODE_JTAG) && tck_rise && ten_sy; // RULE10
    wire beat = act_beat || pas_beat || jtg_beat;
    wire [31:0] beat_data = act_beat ? act_lanes : jtg_beat ? {31'h0, tdi_sy} : pdata_s;
    wire word_done = beat && (beat_ff == beats_per_word(wcode_ff) - 6'h1);
    wire last_word = word_done && (rx_cnt_ff == 16'(WORDS - 1));
    wire overrun = word_done && stall;
    wire cm_take = !wvalid_ff || cm_wready;
    wire all_written = (cm_cnt_ff == 16'(WORDS));

    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (cr_rise) begin
                    if (!width_ok) nxt_state = ST_ERR;
                    else if (mode_s == MODE_ACTIVE) nxt_state = ST_WAKE; // RULE4
                    else nxt_state = ST_STREAM;
                end
            end
            ST_WAKE: if (phase_end_wake) nxt_state = ST_GAP; // RULE6
            ST_GAP: if (wait_ff == 16'(WAKE_CYC - 1)) nxt_state = ST_CMD; // RULE7
            ST_CMD: if (phase_end_cmd) nxt_state = ST_DUMMY;
            ST_DUMMY: if (phase_end_dummy) nxt_state = ST_DATA;
            ST_DATA: if (last_word) nxt_state = ST_DRAIN; // RULE11
            ST_STREAM: if (last_word) nxt_state = ST_DRAIN;
            ST_DRAIN: if (all_written) nxt_state = ST_USER; // RULE1
            ST_USER: nxt_state = ST_USER;
            ST_ERR: nxt_state = ST_ERR;
            default: nxt_state = ST_IDLE;
        endcase
        if (overrun) nxt_state = ST_ERR;
        if (!cr_s) nxt_state = ST_IDLE;
    end

    // state, straps and error flag
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            mode_ff <= MODE_ACTIVE;
            wcode_ff <= WID_X1;
            err_ff <= 1'b0;
            user_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_IDLE && cr_rise) begin
                mode_ff <= mode_s;
                wcode_ff <= width_s;
            end
            err_ff <= (nxt_state == ST_ERR);
            user_ff <= (nxt_state == ST_USER); // RULE1
        end
    end

    // internal flash clock divider and bit counter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_ff <= '0;
            sck_ff <= 1'b0;
            bit_ff <= '0;
            wait_ff <= '0;
        end else begin
            if (!sck_state || state_ff != nxt_state) begin
                div_ff <= '0;
                sck_ff <= 1'b0;
                bit_ff <= '0;
            end else if (tick) begin
                div_ff <= '0;
                sck_ff <= !sck_ff; // RULE5
                if (sck_ff) bit_ff <= bit_ff + 6'h1;
            end else if (!stall) begin
                div_ff <= div_ff + 1'b1;
            end
            wait_ff <= (state_ff == ST_GAP) ? wait_ff + 16'h1 : '0;
        end
    end

    // flash select, command shifter and lane enables
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cs_n_ff <= 1'b1;
            tx_sr_ff <= '0;
            oe_ff <= '0;
        end else begin
            if (state_ff == ST_IDLE && nxt_state == ST_WAKE) begin
                cs_n_ff <= 1'b0;
                tx_sr_ff <= {CMD_WAKE, 24'h000000}; // RULE6
                oe_ff <= 4'h1;
            end else if (state_ff == ST_GAP && nxt_state == ST_CMD) begin
                cs_n_ff <= 1'b0;
                tx_sr_ff <= {read_cmd, READ_ADDR}; // RULE7
                oe_ff <= 4'h1;
            end else if (nxt_state == ST_DUMMY || nxt_state == ST_DATA) begin
                oe_ff <= '0;
                cs_n_ff <= 1'b0; // RULE11
            end else if (nxt_state != ST_WAKE && nxt_state != ST_CMD) begin
                cs_n_ff <= 1'b1;
                oe_ff <= '0;
            end
            if (fall_tick && (state_ff == ST_WAKE || state_ff == ST_CMD)) begin
                tx_sr_ff <= {tx_sr_ff[30:0], 1'b0};
            end
        end
    end

    // word assembly and counters
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            asm_ff <= '0;
            beat_ff <= '0;
            word_vld_ff <= 1'b0;
            rx_cnt_ff <= '0;
        end else begin
            if (beat) begin
                asm_ff <= shift_in(asm_ff, beat_data, wcode_ff);
                beat_ff <= word_done ? 6'h0 : beat_ff + 6'h1;
            end
            // a cut load leaves no partial word behind
            if (state_ff == ST_IDLE) beat_ff <= '0;
            if (word_done) word_vld_ff <= 1'b1;
            else if (fifo_in_ready) word_vld_ff <= 1'b0;
            if (state_ff == ST_IDLE) rx_cnt_ff <= '0;
            else if (word_done) rx_cnt_ff <= rx_cnt_ff + 16'h1;
        end
    end

    fcl_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .in_valid(word_vld_ff),
        .in_ready(fifo_in_ready),
        .in_data(asm_ff),
        .out_valid(fifo_out_valid),
        .out_ready(cm_take),
        .out_data(fifo_out_data)
    );

    // configuration memory write stage
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wvalid_ff <= 1'b0;
            wdata_ff <= '0;
            cm_cnt_ff <= '0;
            busy_ff <= 1'b0;
        end else begin
            if (cm_take) begin
                wvalid_ff <= fifo_out_valid;
                wdata_ff <= fifo_out_data;
            end
            if (state_ff == ST_IDLE) cm_cnt_ff <= '0;
            else if (wvalid_ff && cm_wready) cm_cnt_ff <= cm_cnt_ff + 16'h1;
            busy_ff <= !fifo_in_ready;
        end
    end

    assign spi_sck = sck_ff;
    assign spi_cs_n = cs_n_ff;
    assign spi_io_out = {3'h0, tx_sr_ff[31]};
    assign spi_io_oe = oe_ff;
    assign pas_busy = busy_ff;
    assign cm_wdata = wdata_ff;
    assign cm_wvalid = wvalid_ff;
    assign user_mode = user_ff;
    assign cfg_error = err_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    chk_user_after_load: assert property (user_ff |-> all_written) else $error("user mode before load"); // RULE1
    chk_width_legal: assert property (state_ff == ST_DATA |-> wcode_ff <= WID_X4) else $error("bad active width"); // RULE2
    chk_start_edge: assert property (state_ff == ST_IDLE && cr_rise && mode_s == MODE_ACTIVE && width_ok
        |=> state_ff == ST_WAKE) else $error("active load not started"); // RULE4
    chk_sck_high_time: assert property ($fell(sck_ff) && $past(cr_s) |-> $past(sck_ff, 4))
        else $error("flash clock too fast"); // RULE5
    chk_wake_first: assert property ($fell(cs_n_ff) && state_ff == ST_WAKE |-> tx_sr_ff[31:24] == CMD_WAKE)
        else $error("first instruction not wake"); // RULE6
    chk_wake_gap: assert property ($fell(cs_n_ff) && state_ff == ST_CMD |-> $past(wait_ff) == 16'(WAKE_CYC - 1)
        && tx_sr_ff[23:0] == READ_ADDR) else $error("read issued too early"); // RULE7
    chk_pass_slave: assert property (mode_ff != MODE_ACTIVE && state_ff == ST_STREAM |-> cs_n_ff && oe_ff == 4'h0)
        else $error("flash driven in slave mode"); // RULE9
    chk_one_read: assert property (state_ff == ST_DATA && $past(state_ff) == ST_DATA |-> !cs_n_ff && $stable(cs_n_ff))
        else $error("read transaction broken"); // RULE11
    cov_active_load: cover property (mode_ff == MODE_ACTIVE && $rose(user_ff));
    cov_passive_load: cover property (mode_ff == MODE_PASSIVE && $rose(user_ff));
    cov_error: cover property ($rose(err_ff));
endmodule

// ===== core/fcl_fix_note.sv
// no logic here; the whole loader sits in fcl_loader.sv

// ===== testbench/fcl_flash_model.sv
// serial flash stand-in that captures instructions and streams pattern words
`timescale 1ns/100ps
module fcl_flash_model (
    input wire logic config_reset_low, // load start pin, clears frame count
    input wire logic spi_sck, // flash clock from loader
    input wire logic spi_cs_n, // flash select, active low
    input wire logic [3:0] spi_io_out, // loader lanes
    input wire logic [2:0] width_sel, // lane count code
    output logic [3:0] flash_io, // lanes driven by flash
    output logic [7:0] wake_byte, // first frame instruction
    output logic [31:0] cmd_word, // read instruction and address
    output int frames // selected frames since load start
);
    int bcnt = 0;
    int w;
    int b;
    logic [31:0] sr = 32'h0;
    logic [31:0] word;
    function automatic logic [31:0] pat(input int k);
        return 32'h9c3a_5e61 ^ {4{k[7:0]}};
    endfunction
    initial begin
        flash_io = 4'h5;
        wake_byte = 8'h00;
        cmd_word = 32'h0;
        frames = 0;
    end
    // frame bookkeeping
    always @(posedge config_reset_low) frames = 0;
    always @(negedge spi_cs_n) begin
        frames = frames + 1;
        bcnt = 0;
    end
    // instruction bits shift in on rising clock
    always @(posedge spi_sck) begin
        if (!spi_cs_n) begin
            sr = {sr[30:0], spi_io_out[0]};
            bcnt = bcnt + 1;
            if (frames == 1 && bcnt == 8) wake_byte = sr[7:0];
            if (frames == 2 && bcnt == 32) cmd_word = sr;
        end
    end
    // next beat after falling clock; lanes scramble unless they carry read data
    always @(negedge spi_sck or posedge spi_cs_n) begin
        #10;
        w = 1 << width_sel;
        flash_io = ~flash_io;
        if (!spi_cs_n && frames == 2 && bcnt >= 40 && cmd_word[23:0] == 24'h000000) begin
            b = bcnt - 40;
            word = pat(b / (32 / w)) << (w * (b % (32 / w)));
            case (w)
                1: flash_io[1] = word[31];
                2: flash_io[1:0] = word[31:30];
                default: flash_io = word[31:28];
            endcase
        end
    end
endmodule

// ===== testbench/fpga_config_loader_tb.sv
// self-checking bench for the configuration loader
`timescale 1ns/100ps
module fpga_config_loader_tb;
    import fcl_pkg::*;
    localparam int NW = 8;
    typedef struct {logic [1:0] mode; logic [2:0] wid; logic err;} fcl_row_s;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic config_reset_low = 1'b0;
    logic [1:0] mode_sel = 2'h0;
    logic [2:0] width_sel = 3'h0;
    logic pas_clk = 1'b0, pas_cs_n = 1'b1, jtag_tck = 1'b0, jtag_cfg_en = 1'b0, jtag_tdi = 1'b0, cm_wready = 1'b1;
    logic [31:0] pas_data = 32'h0;
    logic spi_sck, spi_cs_n, pas_busy, cm_wvalid, user_mode, cfg_error, last_sck;
    logic [3:0] spi_io_out, spi_io_oe, spi_io_in, flash_io;
    logic [31:0] cm_wdata, cmd_word;
    logic [7:0] wake_byte;
    int frames, got_cnt = 0, gap_cnt = 0, stall_cnt = 0, tog_cnt = 0, cyc = 0, miscompares = 0, checks_done = 0;
    fcl_row_s rows [12] = '{'{MODE_ACTIVE, WID_X1, 1'b0}, '{MODE_ACTIVE, 3'h1, 1'b0}, '{MODE_ACTIVE, WID_X4, 1'b0},
        '{MODE_ACTIVE, 3'h3, 1'b1}, '{MODE_PASSIVE, WID_X1, 1'b0}, '{MODE_PASSIVE, 3'h1, 1'b0},
        '{MODE_PASSIVE, WID_X4, 1'b0}, '{MODE_PASSIVE, 3'h3, 1'b0}, '{MODE_PASSIVE, 3'h4, 1'b0},
        '{MODE_PASSIVE, WID_X32, 1'b0}, '{MODE_JTAG, WID_X1, 1'b0}, '{MODE_JTAG, WID_X4, 1'b1}};
    always #10 clock = ~clock;
    // lanes resolve from loader enables and flash drive
    assign spi_io_in = (spi_io_oe & spi_io_out) | (~spi_io_oe & flash_io);
    fcl_loader #(.WORDS(NW), .FIFO_DEPTH(4)) DUT (.clock(clock), .rstn(rstn), .config_reset_low(config_reset_low),
        .mode_sel(mode_sel), .width_sel(width_sel), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_io_out(spi_io_out),
        .spi_io_oe(spi_io_oe), .spi_io_in(spi_io_in), .pas_clk(pas_clk), .pas_cs_n(pas_cs_n), .pas_data(pas_data),
        .pas_busy(pas_busy), .jtag_tck(jtag_tck), .jtag_cfg_en(jtag_cfg_en), .jtag_tdi(jtag_tdi),
        .cm_wdata(cm_wdata), .cm_wvalid(cm_wvalid), .cm_wready(cm_wready), .user_mode(user_mode),
        .cfg_error(cfg_error));
    fcl_flash_model flash (.config_reset_low(config_reset_low), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_io_out(spi_io_out), .width_sel(width_sel), .flash_io(flash_io), .wake_byte(wake_byte),
        .cmd_word(cmd_word), .frames(frames));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] pat(input int k);
        return 32'h9c3a_5e61 ^ {4{k[7:0]}};
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (exp !== got) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // memory sink with optional long stall, gap and clock-pause counters, timeout
    always @(posedge clock) begin
        cyc++;
        if (cm_wvalid === 1'b1 && cm_wready === 1'b1) begin
            chk("cm_wdata", pat(got_cnt), cm_wdata);
            got_cnt++;
        end
        if (frames == 1 && spi_cs_n === 1'b1) gap_cnt++;
        if (stall_cnt > 0 && stall_cnt <= 200 && spi_sck !== last_sck) tog_cnt++;
        if (stall_cnt > 0 && cm_wvalid === 1'b1) stall_cnt--;
        last_sck = spi_sck;
        cm_wready <= (stall_cnt == 0);
        if (cyc == 60000) begin
            miscompares++;
            stop_test();
        end
    end
    // master side for passive and test-port loads
    task automatic send_words(input logic [2:0] w, input logic jt);
        int wb;
        int n;
        logic [31:0] d;
        wb = 1 << w;
        repeat (10) @(posedge clock);
        pas_cs_n <= jt;
        jtag_cfg_en <= jt;
        for (int k = 0; k < NW; k++) begin
            d = pat(k);
            for (int b = 0; b < 32 / wb; b++) begin
                n = 0;
                while (pas_busy === 1'b1 && n < 2000) begin
                    @(posedge clock);
                    n++;
                end
                pas_data <= d >> (32 - wb);
                jtag_tdi <= d[31];
                d = d << wb;
                repeat (3) @(posedge clock);
                if (jt) jtag_tck <= 1'b1;
                else pas_clk <= 1'b1;
                repeat (3) @(posedge clock);
                jtag_tck <= 1'b0;
                pas_clk <= 1'b0;
            end
        end
        repeat (3) @(posedge clock);
        pas_cs_n <= 1'b1;
        jtag_cfg_en <= 1'b0;
    endtask
    // one full load, or a rejected strap setting, in the given mode and width
    task automatic run_case(input logic [1:0] m, input logic [2:0] w, input logic e);
        int n;
        @(posedge clock);
        mode_sel <= m;
        width_sel <= w;
        config_reset_low <= 1'b0;
        repeat (40) @(posedge clock);
        #1;
        chk("spi_cs_n held", 32'h1, spi_cs_n);
        got_cnt = 0;
        gap_cnt = 0;
        config_reset_low <= 1'b1;
        if (!e && m != MODE_ACTIVE) send_words(w, m == MODE_JTAG);
        n = 0;
        while (user_mode !== 1'b1 && cfg_error !== 1'b1 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        repeat (2) @(posedge clock);
        #1;
        chk("cfg_error", e, cfg_error);
        chk("user_mode", !e, user_mode);
        chk("words", e ? 0 : NW, got_cnt);
        if (m == MODE_ACTIVE && !e) begin
            chk("frames", 2, frames);
            chk("wake", CMD_WAKE, wake_byte);
            chk("read", {w == WID_X1 ? CMD_READ_X1 : w == WID_X4 ? CMD_READ_X4 : CMD_READ_X2, READ_ADDR}, cmd_word);
            chk("gap", 1, gap_cnt >= WAKE_CYC);
            chk("spi_cs_n end", 1, spi_cs_n);
        end
        $display("case mode %0d width %0d done", m, w);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int n;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        chk("spi_cs_n", 1, spi_cs_n);
        chk("spi_sck", 0, spi_sck);
        chk("spi_io_oe", 0, spi_io_oe);
        chk("user_mode", 0, user_mode);
        chk("cm_wvalid", 0, cm_wvalid);
        $display("reset test done");
        foreach (rows[i]) run_case(rows[i].mode, rows[i].wid, rows[i].err);
        // pin pulled low in the middle of the data stream
        @(posedge clock);
        config_reset_low <= 1'b0;
        mode_sel <= MODE_ACTIVE;
        width_sel <= WID_X1;
        repeat (5) @(posedge clock);
        config_reset_low <= 1'b1;
        #1 got_cnt = 0;
        n = 0;
        while (got_cnt < 2 && n < 6000) begin
            @(posedge clock);
            n++;
        end
        config_reset_low <= 1'b0;
        repeat (6) @(posedge clock);
        #1;
        chk("spi_cs_n abort", 1, spi_cs_n);
        chk("user_mode abort", 0, user_mode);
        $display("abort test done");
        // memory side stalls long enough to fill the fifo
        stall_cnt = 600;
        tog_cnt = 0;
        run_case(MODE_ACTIVE, WID_X4, 1'b0);
        chk("sck toggles in stall", 0, tog_cnt);
        $display("stall test done");
        stop_test();
    end
endmodule
